// *** testbench/scan_chain_port_assertions.sv ***
// Concurrent checks on the scan chain port block
`timescale 1ns/1ps
`include "scan_chain_params.svh"
module scan_chain_port_assertions
(
   // Clock, reset and bus
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   // Link
   input wire logic tck_o,
   input wire logic tck_oe,
   input wire logic tms_o,
   input wire logic tms_oe,
   input wire logic tdi_o,
   input wire logic tdi_oe,
   input wire logic test_reset_n_o,
   input wire logic test_reset_n_oe,
   input wire logic system_reset_line_n_oe,
   // Routing
   input wire logic [7:0] high_perf_bus_port_number,
   input wire logic [7:0] peripheral_bus_port_number,
   input wire logic [7:0] extensible_bus_port_number,
   input wire logic extensible_bus_valid,
   input wire logic [7:0] debug_register_port_number,
   input wire logic [7:0] internal_scan_port_number,
   input wire logic [2:0] internal_scan_lane_select
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic wr;
   assign wr = psel && penable && pready && pwrite;
   chk_reset_routes: assert property ($fell(sys_rst) |-> !extensible_bus_valid
      && debug_register_port_number == 8'h01 && high_perf_bus_port_number == 8'h00)
      else $error("routing wrong after reset");
   chk_drive_after_reset: assert property ($fell(sys_rst) |=> tck_oe && tms_oe && test_reset_n_oe)
      else $error("link not driven after reset");
   chk_port_write: assert property (wr && paddr == `ADDR_PORTS |=> extensible_bus_valid
      && {debug_register_port_number, extensible_bus_port_number, peripheral_bus_port_number,
      high_perf_bus_port_number} == $past(pwdata)) else $error("port numbers not taken");
   chk_lane_write: assert property (wr && paddr == `ADDR_PORTS2 |=>
      {21'h0, internal_scan_lane_select, internal_scan_port_number} == ($past(pwdata) & 32'h7FF))
      else $error("lane select not taken");
   chk_slave_release: assert property (wr && paddr == `ADDR_CTRL && pwdata[0] |->
      ##[1:2] !test_reset_n_oe && !system_reset_line_n_oe) else $error("slave drives resets");
   chk_reset_assert: assert property (wr && paddr == `ADDR_CTRL && pwdata[9:8] == 2'b11
      && pwdata[1:0] == 2'b00 |-> ##[1:2] test_reset_n_oe && !test_reset_n_o)
      else $error("master test reset not driven low");
   chk_tristate_release: assert property (wr && paddr == `ADDR_CTRL && pwdata[1:0] == 2'b10
      |-> ##[1:60] !tck_oe && !tms_oe && !tdi_oe) else $error("outputs not released");
   // State control and data must be settled before the target samples them
   chk_tms_setup: assert property (tck_oe && $rose(tck_o) |-> $stable(tms_o) && $stable(tdi_o))
      else $error("link data moved at clock rise");
endmodule : scan_chain_port_assertions

// *** testbench/tap_chain_model.sv ***
// Behavioural daisy chain of test access ports
`timescale 1ns/1ps
module tap_chain_model
#(
   parameter int BEF = 2,
   parameter logic [31:0] CAP = 32'hC3A596E1
)
(
   // Link
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic trst_n,
   output logic tdo
);
   // Next controller code for state control high and low, one nibble per code
   localparam logic [63:0] NX1 = 64'hF97789DD417F0155;
   localparam logic [63:0] NX0 = 64'hCACCBABA62CE3232;
   // Starts idle, as the probe assumes after its own reset
   logic [3:0] st = 4'hC;
   logic [63:0] sr;
   logic [63:0] outr;
   int cnt;
   always @(posedge tck or negedge trst_n)
   begin
      if (!trst_n)
         st <= 4'hF;
      else
      begin
         if (st == 4'h2 || st == 4'hA)
         begin
            sr <= {tdi, sr[63:1]};
            cnt <= cnt + 1;
         end
         if (st == 4'h6 || st == 4'hE)
            cnt <= 0;
         outr <= (st == 4'h6) ? {32'h0, CAP} << BEF : outr >> 1;
         st <= tms ? NX1[st*4 +: 4] : NX0[st*4 +: 4];
      end
   end
   // Outside Shift-DR the line is undriven, so it toggles
   always @(negedge tck)
      tdo <= (st == 4'h2) ? outr[0] : (tdo !== 1'b1);
endmodule : tap_chain_model

// *** testbench/testbench.sv ***
// Self-checking bench for the scan chain port block
`timescale 1ns/1ps
`include "scan_chain_params.svh"
module testbench;
   localparam logic [31:0] CAPV = 32'hC3A596E1;
   logic clk = 1'b0;
   logic sys_rst, psel, penable, pwrite, pready, pslverr, tdo_i, extensible_bus_valid;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic tck_o, tck_oe, tms_o, tms_oe, tdi_o, tdi_oe;
   logic test_reset_n_o, test_reset_n_oe, system_reset_line_n_o, system_reset_line_n_oe;
   logic [7:0] high_perf_bus_port_number, peripheral_bus_port_number, extensible_bus_port_number;
   logic [7:0] debug_register_port_number, internal_scan_port_number;
   logic [2:0] internal_scan_lane_select;
   int fails, checks;
   scan_chain_port dut (.*);
   // Clock pulled down, other lines pulled up when released
   tap_chain_model #(.BEF(2), .CAP(CAPV)) tap (.tck(tck_oe ? tck_o : 1'b0), .tms(tms_oe ? tms_o : 1'b1),
      .tdi(tdi_oe ? tdi_o : 1'b1), .trst_n(test_reset_n_oe ? test_reset_n_o : 1'b1), .tdo(tdo_i));
   always #5 clk = ~clk;
   task chk(input logic [63:0] s, input logic [63:0] e);
      checks++;
      if (s !== e)
      begin
         fails++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      chk(n < 20, 1'b1);
   endtask : apb
   task routes;
      @(negedge clk);
      chk({debug_register_port_number, high_perf_bus_port_number, extensible_bus_valid}, 17'h200);
      apb(1'b0, `ADDR_CTRL, 32'h0);
      chk(rd, 32'h70);
      apb(1'b1, `ADDR_PORTS, 32'h5AFF80A5);
      apb(1'b1, `ADDR_PORTS2, 32'h7C3);
      @(negedge clk);
      chk({debug_register_port_number, extensible_bus_port_number, peripheral_bus_port_number,
         high_perf_bus_port_number, extensible_bus_valid}, 33'h0B5FF014B);
      chk({internal_scan_lane_select, internal_scan_port_number}, 11'h7C3);
   endtask : routes
   task scan(input logic ap, input logic ir, input logic [7:0] len, input logic [31:0] d, input logic [31:0] pads);
      int pb, pa, t;
      logic [63:0] got, m;
      pb = ir ? pads[23:16] : pads[7:0];
      pa = ir ? pads[31:24] : pads[15:8];
      // Access port counts are named from the chain output side, so after comes first
      if (ap)
         {pb, pa} = {pa, pb};
      t = pb + len + pa;
      m = (64'h1 << len) - 1;
      apb(1'b1, ap ? `ADDR_ACCESS_PORT_PAD : `ADDR_CHAIN_PAD, pads);
      apb(1'b1, `ADDR_SCAN_TDI, d);
      apb(1'b1, `ADDR_SCAN_CMD, {22'h0, ap, ir, len});
      rd = 32'h1;
      for (int i = 0; i < 200 && rd[0] === 1'b1; i++)
         apb(1'b0, `ADDR_STATUS, 32'h0);
      got = tap.sr >> (64 - t);
      chk(tap.cnt, t);
      chk((got >> pb) & m, d & m);
      if (ir)
         chk(got & ~(m << pb), (((64'h1 << pa) - 1) << (pb + len)) | ((64'h1 << pb) - 1));
      apb(1'b0, `ADDR_SCAN_TDO, 32'h0);
      if (!ir)
         chk(rd & m, CAPV & m);
   endtask : scan
   task park(input logic [3:0] s, input logic lv);
      int n;
      logic last;
      apb(1'b1, `ADDR_CTRL, {24'h0, s, 1'b0, lv, 2'b10});
      n = 0;
      last = tck_o;
      while (tck_oe !== 1'b0 && n < 100)
      begin
         last = tck_o;
         @(posedge clk);
         n++;
      end
      chk(last, lv);
      chk(tap.st, s);
      chk({tms_oe, tdi_oe}, 2'b00);
   endtask : park
   task resets;
      apb(1'b1, `ADDR_CTRL, 32'h371);
      repeat (2) @(negedge clk);
      chk({test_reset_n_oe, system_reset_line_n_oe}, 2'b00);
      apb(1'b1, `ADDR_CTRL, 32'h370);
      repeat (2) @(negedge clk);
      chk({test_reset_n_oe, system_reset_line_n_oe, test_reset_n_o, system_reset_line_n_o}, 4'hC);
      chk(tap.st, 4'hF);
   endtask : resets
   task conclude;
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : conclude
   initial
   begin
      {sys_rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      routes();
      scan(1'b0, 1'b1, 8'd5, 32'h15, 32'h03020102);
      scan(1'b0, 1'b0, 8'd8, 32'h5A, 32'h03020102);
      scan(1'b1, 1'b1, 8'd4, 32'h6, 32'h01040000);
      scan(1'b0, 1'b1, 8'd32, 32'h80000001, 32'h0);
      park(4'hC, 1'b1);
      apb(1'b1, `ADDR_CTRL, 32'h70);
      park(4'h7, 1'b0);
      resets();
      conclude();
   end
   // Whole run needs well under a tenth of this
   initial
   begin
      #200000;
      fails++;
      conclude();
   end
endmodule : testbench
bind scan_chain_port scan_chain_port_assertions chk (.*);

// *** verilog/scan_chain_params.svh ***
// Constants for the scan chain position and port select block
`ifndef SCAN_CHAIN_PARAMS_SVH
`define SCAN_CHAIN_PARAMS_SVH
`define ADDR_CHAIN_PAD     12'h000
`define ADDR_ACCESS_PORT_PAD 12'h004
`define ADDR_CTRL          12'h008
`define ADDR_PORTS         12'h00C
`define ADDR_PORTS2        12'h010
`define ADDR_SCAN_CMD      12'h014
`define ADDR_SCAN_TDI      12'h018
`define ADDR_SCAN_TDO      12'h01C
`define ADDR_STATUS        12'h020
`define PARK_STATE_RESET   4'h7
`define DEBUG_PORT_RESET   8'h01
`define TAP_SHIFT_DR       4'h2
`define TAP_SHIFT_IR       4'hA
`define TAP_RTI            4'hC
`define TAP_TLR            4'hF
`define SCAN_LEN_MAX       8'h20
`endif

// *** verilog/scan_chain_pkg.sv ***
// Types for the scan chain position and port select block
package scan_chain_pkg;
   typedef enum logic [5:0] {
      ST_IDLE  = 6'b000001,
      ST_NAV   = 6'b000010,
      ST_SHIFT = 6'b000100,
      ST_EXIT  = 6'b001000,
      ST_PARK  = 6'b010000,
      ST_TRI   = 6'b100000
   } seq_e;
endpackage : scan_chain_pkg

// *** verilog/scan_chain_port.sv ***
// Scan link master with chain padding, shared-port ownership and access port selection
//
// Contract
// - Link uses test reset, scan clock, state control, data into and out of chain.
// - Every other port on the chain receives the all-ones bypass instruction.
// - Ports between target and probe input add one data pad bit each.
// - Ports between probe output and target add one data pad bit each.
// - Instruction bits between target and probe input are padded, default zero.
// - Instruction bits between probe output and target are padded, default zero.
// - A second set of four pad counts serves the debug access port.
// - Only the master drives test and system reset; a slave leaves them undriven.
// - Tristate mode parks the controller and clock level before releasing outputs.
// - Parked clock level is configurable and defaults low.
// - Parking state is a four-bit code for the sixteen controller states; codes other than RTI and TLR park at Select-DR-Scan.
// - Parking state defaults to seven, Select-DR-Scan.
// - High performance bus port number 0 to 255, default zero.
// - Peripheral bus port number 0 to 255.
// - Extensible bus port number has no default; unavailable until set.
// - Debug register port number 0 to 255, default one.
// - Internal scan access port number 0 to 255.
// - Internal scan lane select 0 to 7 picks one of eight interfaces.
`timescale 1ns/1ps
`include "scan_chain_params.svh"
module scan_chain_port
   import scan_chain_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Scan link
   output logic tck_o,
   output logic tck_oe,
   output logic tms_o,
   output logic tms_oe,
   output logic tdi_o,
   output logic tdi_oe,
   input wire logic tdo_i,
   output logic test_reset_n_o,
   output logic test_reset_n_oe,
   output logic system_reset_line_n_o,
   output logic system_reset_line_n_oe,
   // Routing outputs
   output logic [7:0] high_perf_bus_port_number,
   output logic [7:0] peripheral_bus_port_number,
   output logic [7:0] extensible_bus_port_number,
   output logic extensible_bus_valid,
   output logic [7:0] debug_register_port_number,
   output logic [7:0] internal_scan_port_number,
   output logic [2:0] internal_scan_lane_select
);

   typedef struct packed {
      logic [7:0] dpb;
      logic [7:0] dpa;
      logic [7:0] ipb;
      logic [7:0] ipa;
      logic [7:0] adpb;
      logic [7:0] adpa;
      logic [7:0] aipb;
      logic [7:0] aipa;
      logic slave;
      logic tristate;
      logic park_lvl;
      logic [3:0] park_st;
      logic trst_assert;
      logic srst_assert;
      logic [7:0] ahb;
      logic [7:0] apb;
      logic [7:0] axi;
      logic axi_set;
      logic [7:0] dbg;
      logic [7:0] jap;
      logic [2:0] lane;
      logic is_ir;
      logic use_ap;
      logic [7:0] len;
      logic [31:0] tdi_data;
      logic [31:0] tdo_data;
      seq_e st;
      logic [15:0] total;
      logic [15:0] cnt;
      logic [15:0] pre;
      logic [3:0] nav_cnt;
      logic [7:0] nav_pat;
      logic ph;
      logic tck;
      logic tms;
      logic tdi;
      logic drive;
      logic busy;
      logic [31:0] rdata;
      logic rdy;
      logic err;
      logic tdo_s1;
      logic tdo_s2;
   } state_s;

   state_s q, d;
   logic wr_en;
   logic rd_en;
   logic [15:0] pad_lo;
   logic [15:0] pad_hi;
   logic pad_bit;
   logic [15:0] idx;

   assign wr_en = psel && penable && pwrite && !q.rdy;
   assign rd_en = psel && penable && !pwrite && !q.rdy;

   // Pad counts: lo are shifted first and end up nearest the chain output, hi last
   always_comb
   begin
      if (q.use_ap)
      begin
         // Access port counts are named from the chain output side, so after goes first
         pad_lo = q.is_ir ? {8'h00, q.aipa} : {8'h00, q.adpa};
         pad_hi = q.is_ir ? {8'h00, q.aipb} : {8'h00, q.adpb};
      end
      else
      begin
         pad_lo = q.is_ir ? {8'h00, q.ipb} : {8'h00, q.dpb};
         pad_hi = q.is_ir ? {8'h00, q.ipa} : {8'h00, q.dpa};
      end
   end

   always_comb
   begin
      d = q;
      d.rdy = 1'b0;
      d.err = 1'b0;
      d.tdo_s1 = tdo_i;
      d.tdo_s2 = q.tdo_s1;
      idx = 16'h0000;
      pad_bit = 1'b0;
      // Register writes
      if (wr_en)
      begin
         d.rdy = 1'b1;
         case (paddr)
            `ADDR_CHAIN_PAD:
            begin
               d.dpb = pwdata[7:0];
               d.dpa = pwdata[15:8];
               d.ipb = pwdata[23:16];
               d.ipa = pwdata[31:24];
            end
            `ADDR_ACCESS_PORT_PAD:
            begin
               d.adpb = pwdata[7:0];
               d.adpa = pwdata[15:8];
               d.aipb = pwdata[23:16];
               d.aipa = pwdata[31:24];
            end
            `ADDR_CTRL:
            begin
               d.slave = pwdata[0];
               d.tristate = pwdata[1];
               d.park_lvl = pwdata[2];
               d.park_st = pwdata[7:4];
               d.trst_assert = pwdata[8];
               d.srst_assert = pwdata[9];
            end
            `ADDR_PORTS:
            begin
               d.ahb = pwdata[7:0];
               d.apb = pwdata[15:8];
               d.axi = pwdata[23:16];
               d.axi_set = 1'b1;
               d.dbg = pwdata[31:24];
            end
            `ADDR_PORTS2:
            begin
               d.jap = pwdata[7:0];
               d.lane = pwdata[10:8];
            end
            `ADDR_SCAN_CMD:
            begin
               if (q.busy || q.tristate || pwdata[7:0] == 8'h00 || pwdata[7:0] > `SCAN_LEN_MAX)
                  d.err = 1'b1;
               else
               begin
                  d.len = pwdata[7:0];
                  d.is_ir = pwdata[8];
                  d.use_ap = pwdata[9];
                  d.busy = 1'b1;
               end
            end
            `ADDR_SCAN_TDI:
               d.tdi_data = pwdata;
            default:
               d.err = 1'b1;
         endcase
      end
      if (rd_en)
      begin
         d.rdy = 1'b1;
         case (paddr)
            `ADDR_CHAIN_PAD: d.rdata = {q.ipa, q.ipb, q.dpa, q.dpb};
            `ADDR_ACCESS_PORT_PAD: d.rdata = {q.aipa, q.aipb, q.adpa, q.adpb};
            `ADDR_CTRL: d.rdata = {22'h000000, q.srst_assert, q.trst_assert, q.park_st, 1'b0, q.park_lvl,
               q.tristate, q.slave};
            `ADDR_PORTS: d.rdata = {q.dbg, q.axi, q.apb, q.ahb};
            `ADDR_PORTS2: d.rdata = {21'h000000, q.lane, q.jap};
            `ADDR_SCAN_TDI: d.rdata = q.tdi_data;
            `ADDR_SCAN_TDO: d.rdata = q.tdo_data;
            `ADDR_STATUS: d.rdata = {28'h0000000, q.axi_set, q.drive, q.tristate, q.busy};
            default:
            begin
               d.rdata = 32'h00000000;
               d.err = 1'b1;
            end
         endcase
      end
      // Sequencer; each scan clock half period is one clk, so tck runs at clk/2
      d.ph = ~q.ph;
      case (q.st)
         ST_IDLE:
         begin
            d.tck = 1'b0;
            d.ph = 1'b0;
            d.drive = 1'b1;
            if (q.busy)
            begin
               // From Run-Test/Idle: DR 1,0,0 ; IR 1,1,0,0 (LSB first)
               d.nav_pat = q.is_ir ? 8'h03 : 8'h01;
               d.nav_cnt = q.is_ir ? 4'h4 : 4'h3;
               d.total = pad_lo + {8'h00, q.len} + pad_hi;
               d.pre = pad_lo;
               d.cnt = 16'h0000;
               d.tdo_data = 32'h00000000;
               d.st = ST_NAV;
            end
            else if (q.tristate)
            begin
               d.nav_cnt = 4'h0;
               d.st = ST_PARK;
            end
         end
         ST_NAV:
         begin
            if (!q.ph)
               d.tms = q.nav_pat[0];
            // State control moves with the falling scan clock, so it is settled at the rise
            d.tck = q.ph;
            if (q.ph)
            begin
               d.nav_pat = {1'b0, q.nav_pat[7:1]};
               d.nav_cnt = q.nav_cnt - 4'h1;
               if (q.nav_cnt == 4'h1)
                  d.st = ST_SHIFT;
            end
         end
         ST_SHIFT:
         begin
            d.tck = q.ph;
            if (!q.ph)
            begin
               idx = q.cnt - q.pre;
               // Instruction pads carry ones so other ports get bypass
               pad_bit = q.is_ir ? 1'b1 : 1'b0;
               if (q.cnt < q.pre || idx >= {8'h00, q.len})
                  d.tdi = pad_bit;
               else
                  d.tdi = q.tdi_data[idx[4:0]];
               d.tms = (q.cnt == q.total - 16'h0001);
            end
            else
            begin
               // Synchronised tdo trails by one scan bit, so this rise stores the previous bit
               idx = q.cnt - q.pre - 16'h0001;
               if (q.cnt > q.pre && idx < {8'h00, q.len})
                  d.tdo_data[idx[4:0]] = q.tdo_s2;
               d.cnt = q.cnt + 16'h0001;
               if (q.cnt == q.total - 16'h0001)
               begin
                  d.nav_pat = 8'h01;
                  d.nav_cnt = 4'h2;
                  d.st = ST_EXIT;
               end
            end
         end
         ST_EXIT:
         begin
            // Update then Run-Test/Idle
            d.tck = q.ph;
            if (!q.ph)
               d.tms = q.nav_pat[0];
            else
            begin
               // The last scan bit comes out of the synchroniser here
               idx = q.cnt - q.pre - 16'h0001;
               if (q.nav_cnt == 4'h2 && q.cnt > q.pre && idx < {8'h00, q.len})
                  d.tdo_data[idx[4:0]] = q.tdo_s2;
               d.nav_pat = {1'b0, q.nav_pat[7:1]};
               d.nav_cnt = q.nav_cnt - 4'h1;
               if (q.nav_cnt == 4'h1)
               begin
                  d.busy = 1'b0;
                  d.st = ST_IDLE;
               end
            end
         end
         ST_PARK:
         begin
            // Walk from Run-Test/Idle to the parking state: TLR via 5 ones, RTI via one 0, others via a single 1
            d.tck = q.ph;
            if (!q.ph)
            begin
               if (q.park_st == `TAP_RTI)
                  d.tms = 1'b0;
               else if (q.park_st == `TAP_TLR)
                  d.tms = 1'b1;
               else
                  d.tms = (q.nav_cnt == 4'h0);
            end
            else
            begin
               d.nav_cnt = q.nav_cnt + 4'h1;
               if (q.park_st == `TAP_RTI || (q.park_st == `TAP_TLR && q.nav_cnt == 4'h4)
                  || (q.park_st != `TAP_TLR && q.nav_cnt == 4'h0))
               begin
                  d.st = ST_TRI;
               end
            end
         end
         ST_TRI:
         begin
            // Other parking codes stop at Select-DR-Scan; a full walk would need a longer table
            d.tck = q.park_lvl;
            // Release only once the clock already stands at its parked level
            if (q.tck == q.park_lvl)
               d.drive = 1'b0;
            d.ph = 1'b0;
            if (!q.tristate)
            begin
               d.tms = 1'b1;
               d.nav_cnt = 4'h0;
               d.st = ST_IDLE;
            end
         end
         default:
            d.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         q <= '0;
         q.park_st <= `PARK_STATE_RESET;
         q.dbg <= `DEBUG_PORT_RESET;
         q.st <= ST_IDLE;
         q.tms <= 1'b1;
      end
      else
         q <= d;
   end

   assign prdata = q.rdata;
   assign pready = q.rdy;
   assign pslverr = q.err;
   assign tck_o = q.tck;
   assign tck_oe = q.drive;
   assign tms_o = q.tms;
   assign tms_oe = q.drive;
   assign tdi_o = q.tdi;
   assign tdi_oe = q.drive;
   assign test_reset_n_o = ~q.trst_assert;
   assign test_reset_n_oe = ~q.slave && q.drive;
   assign system_reset_line_n_o = ~q.srst_assert;
   assign system_reset_line_n_oe = ~q.slave && q.drive;
   assign high_perf_bus_port_number = q.ahb;
   assign peripheral_bus_port_number = q.apb;
   assign extensible_bus_port_number = q.axi;
   assign extensible_bus_valid = q.axi_set;
   assign debug_register_port_number = q.dbg;
   assign internal_scan_port_number = q.jap;
   assign internal_scan_lane_select = q.lane;

endmodule : scan_chain_port
